// ---- src/tpo_pkg.sv ----
// constants, register map and helpers of the timed pattern output block
// assumes a single 125 MHz clock and a classic wishbone master
// How it works
// R1: group3 select field picks timer channel 0-3
// R2: high enable bits gate copy to port B
// R3: low enable bits gate copy to port A
// R4: shared 2/3 trigger: all data first address
// R5: split 2/3 trigger: halves split, unused reads one
// R6: split 0/1 trigger: halves split, unused reads one
// R7: normal uses match A; non-overlap uses A and B
// R8: enabled bits copy on trigger, others hold
package tpo_pkg;
  localparam int unsigned TPO_IDX_W = 16;
  // register indices; byte address is four times the index
  localparam logic [15:0] TPO_IDX_TRIG_SEL = 16'h00a0;
  localparam logic [15:0] TPO_IDX_MODE = 16'h00a1;
  localparam logic [15:0] TPO_IDX_EN_HIGH = 16'h00a2;
  localparam logic [15:0] TPO_IDX_EN_LOW = 16'h00a3;
  localparam logic [15:0] TPO_IDX_UPPER_A = 16'hffa4;
  localparam logic [15:0] TPO_IDX_LOWER_A = 16'hffa5;
  localparam logic [15:0] TPO_IDX_UPPER_B = 16'hffa6;
  localparam logic [15:0] TPO_IDX_LOWER_B = 16'hffa7;
  // reset values
  localparam logic [7:0] TPO_RST_TRIG_SEL = 8'hff;
  localparam logic [3:0] TPO_RST_MODE = 4'h0;
  localparam logic [7:0] TPO_RST_EN = 8'h00;
  localparam logic [15:0] TPO_RST_NEXT = 16'h0000;
  localparam logic [15:0] TPO_RST_LATCH = 16'h0000;
  localparam logic [3:0] TPO_UNUSED_NIB = 4'hf;
  localparam logic [7:0] TPO_UNUSED_BYTE = 8'hff;
  // field positions of the trigger select register, two bits per group
  localparam int unsigned TPO_SEL_W = 2;
  localparam int unsigned TPO_GROUPS = 4;

  typedef enum logic [1:0] {
    TPO_WB_IDLE = 2'b01,
    TPO_WB_ACK = 2'b10
  } tpo_wb_state_e;

  // channel strobe chosen by a two-bit select code
  function automatic logic tpo_pick(input logic [3:0] strobes,
                                    input logic [1:0] sel);
    tpo_pick = strobes[sel];
  endfunction : tpo_pick

  // select code of group g out of the trigger select register
  function automatic logic [1:0] tpo_group_sel(input logic [7:0] tsel,
                                               input int unsigned g);
    tpo_group_sel = tsel[g*TPO_SEL_W +: TPO_SEL_W];
  endfunction : tpo_group_sel
endpackage : tpo_pkg

// ---- src/tpo_trig_if.sv ----
// trigger strobes passed between the register block and the trigger unit
// assumes both ends sit on the same clock
interface tpo_trig_if;
  logic [3:0] cmp_a;
  logic [3:0] cmp_b;
  logic [7:0] trig_sel;
  logic [3:0] non_overlap;
  logic [3:0] fire_a;
  logic [3:0] fire_b;
  modport regs (output cmp_a, output cmp_b, output trig_sel,
                output non_overlap, input fire_a, input fire_b);
  modport unit (input cmp_a, input cmp_b, input trig_sel,
                input non_overlap, output fire_a, output fire_b);
endinterface : tpo_trig_if

// ---- src/tpo_trig_unit.sv ----
// per-group trigger decode: channel choice and mode gating
// assumes compare strobes are one-cycle pulses on the system clock
module tpo_trig_unit (
  tpo_trig_if.unit trig
);
  always_comb begin
    for (int unsigned g = 0; g < tpo_pkg::TPO_GROUPS; g++) begin
      trig.fire_a[g] = tpo_pkg::tpo_pick(trig.cmp_a,
        tpo_pkg::tpo_group_sel(trig.trig_sel, g)); // R1
      // match B only matters in non-overlap mode
      trig.fire_b[g] = trig.non_overlap[g] & tpo_pkg::tpo_pick(trig.cmp_b,
        tpo_pkg::tpo_group_sel(trig.trig_sel, g)); // R7
    end
  end
endmodule : tpo_trig_unit

// ---- src/tpo_top.sv ----
// timed pattern output: wishbone registers, next data and port latches
// assumes synchronous active-high reset and one-cycle compare strobes
//
// Design decision made here: the Wishbone register port.
module tpo_top (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [17:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [3:0] cmp_match_a_in,
  input wire logic [3:0] cmp_match_b_in,
  output logic [7:0] port_a_latch_out,
  output logic [7:0] port_b_latch_out
);
  tpo_trig_if trig ();
  tpo_trig_unit u_trig (.trig(trig));

  tpo_pkg::tpo_wb_state_e wb_state_reg;
  logic [7:0] pattern_trigger_select_reg;
  logic [3:0] mode_reg;
  logic [7:0] next_data_enable_high_reg;
  logic [7:0] next_data_enable_low_reg;
  logic [15:0] next_data_bit_reg;
  logic [15:0] latch_reg;
  logic [15:0] latch_next;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic [15:0] idx;
  logic req;
  logic wr;
  logic share_hi;
  logic share_lo;
  logic [15:0] enable_all;
  logic [7:0] upper_a_rd;
  logic [7:0] upper_b_rd;
  logic [7:0] lower_a_rd;
  logic [7:0] lower_b_rd;

  assign trig.cmp_a = cmp_match_a_in;
  assign trig.cmp_b = cmp_match_b_in;
  assign trig.trig_sel = pattern_trigger_select_reg;
  assign trig.non_overlap = mode_reg;

  assign idx = wb_adr_in[17:2];
  assign req = wb_cyc_in & wb_stb_in & (wb_state_reg == tpo_pkg::TPO_WB_IDLE);
  // writes take effect on the ack edge; only byte lane 0 carries data
  assign wr = req & wb_we_in & wb_sel_in[0];
  assign wb_ack_out = wb_state_reg == tpo_pkg::TPO_WB_ACK;
  assign wb_dat_out = rdata_reg;

  // groups share a trigger when their select codes match
  assign share_hi = tpo_pkg::tpo_group_sel(pattern_trigger_select_reg, 2) ==
                    tpo_pkg::tpo_group_sel(pattern_trigger_select_reg, 3);
  assign share_lo = tpo_pkg::tpo_group_sel(pattern_trigger_select_reg, 0) ==
                    tpo_pkg::tpo_group_sel(pattern_trigger_select_reg, 1);
  assign enable_all = {next_data_enable_high_reg, next_data_enable_low_reg};

  // first address of a pair: all eight bits when shared, else high nibble
  function automatic logic [7:0] first_view(input logic [7:0] nd,
                                            input logic shared);
    if (shared) begin
      first_view = nd;
    end else begin
      first_view = {nd[7:4], tpo_pkg::TPO_UNUSED_NIB};
    end
  endfunction : first_view

  // second address of a pair: reserved when shared, else low nibble
  function automatic logic [7:0] second_view(input logic [7:0] nd,
                                             input logic shared);
    if (shared) begin
      second_view = tpo_pkg::TPO_UNUSED_BYTE;
    end else begin
      second_view = {tpo_pkg::TPO_UNUSED_NIB, nd[3:0]};
    end
  endfunction : second_view

  // read views of the next data registers, layout follows trigger sharing
  assign upper_a_rd = first_view(next_data_bit_reg[15:8], share_hi); // R4 R5
  assign upper_b_rd = second_view(next_data_bit_reg[15:8], share_hi); // R4 R5
  assign lower_a_rd = first_view(next_data_bit_reg[7:0], share_lo); // R6
  assign lower_b_rd = second_view(next_data_bit_reg[7:0], share_lo); // R6

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (idx)
      tpo_pkg::TPO_IDX_TRIG_SEL: rdata_next[7:0] = pattern_trigger_select_reg;
      tpo_pkg::TPO_IDX_MODE: rdata_next[3:0] = mode_reg;
      tpo_pkg::TPO_IDX_EN_HIGH: rdata_next[7:0] = next_data_enable_high_reg;
      tpo_pkg::TPO_IDX_EN_LOW: rdata_next[7:0] = next_data_enable_low_reg;
      tpo_pkg::TPO_IDX_UPPER_A: rdata_next[7:0] = upper_a_rd;
      tpo_pkg::TPO_IDX_UPPER_B: rdata_next[7:0] = upper_b_rd;
      tpo_pkg::TPO_IDX_LOWER_A: rdata_next[7:0] = lower_a_rd;
      tpo_pkg::TPO_IDX_LOWER_B: rdata_next[7:0] = lower_b_rd;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // one wait-free ack per request, then one idle cycle before the next
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wb_state_reg <= tpo_pkg::TPO_WB_IDLE;
    end else begin
      case (wb_state_reg)
        tpo_pkg::TPO_WB_IDLE: begin
          if (req) begin
            wb_state_reg <= tpo_pkg::TPO_WB_ACK;
          end
        end
        tpo_pkg::TPO_WB_ACK: wb_state_reg <= tpo_pkg::TPO_WB_IDLE;
        default: wb_state_reg <= tpo_pkg::TPO_WB_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pattern_trigger_select_reg <= tpo_pkg::TPO_RST_TRIG_SEL;
      mode_reg <= tpo_pkg::TPO_RST_MODE;
    end else if (wr) begin
      case (idx)
        tpo_pkg::TPO_IDX_TRIG_SEL: begin
          pattern_trigger_select_reg <= wb_dat_in[7:0]; // R1
        end
        tpo_pkg::TPO_IDX_MODE: mode_reg <= wb_dat_in[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      next_data_enable_high_reg <= tpo_pkg::TPO_RST_EN; // R2
      next_data_enable_low_reg <= tpo_pkg::TPO_RST_EN; // R3
    end else if (wr) begin
      case (idx)
        tpo_pkg::TPO_IDX_EN_HIGH: next_data_enable_high_reg <= wb_dat_in[7:0];
        tpo_pkg::TPO_IDX_EN_LOW: next_data_enable_low_reg <= wb_dat_in[7:0];
        default: ;
      endcase
    end
  end

  // next data: which bits a write reaches depends on trigger sharing
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      next_data_bit_reg <= tpo_pkg::TPO_RST_NEXT;
    end else if (wr) begin
      case (idx)
        tpo_pkg::TPO_IDX_UPPER_A: begin
          next_data_bit_reg[15:12] <= wb_dat_in[7:4]; // R5
          if (share_hi) begin
            next_data_bit_reg[11:8] <= wb_dat_in[3:0]; // R4
          end
        end
        tpo_pkg::TPO_IDX_UPPER_B: begin
          // fully reserved while groups 2 and 3 share a trigger
          if (!share_hi) begin
            next_data_bit_reg[11:8] <= wb_dat_in[3:0]; // R5
          end
        end
        tpo_pkg::TPO_IDX_LOWER_A: begin
          next_data_bit_reg[7:4] <= wb_dat_in[7:4]; // R6
          if (share_lo) begin
            next_data_bit_reg[3:0] <= wb_dat_in[3:0];
          end
        end
        tpo_pkg::TPO_IDX_LOWER_B: begin
          if (!share_lo) begin
            next_data_bit_reg[3:0] <= wb_dat_in[3:0]; // R6
          end
        end
        default: ;
      endcase
    end
  end

  // one group of four pins on its own triggers
  function automatic logic [3:0] group_update(input logic [3:0] cur,
                                              input logic [3:0] nxt,
                                              input logic [3:0] en,
                                              input logic fa,
                                              input logic fb);
    group_update = cur;
    // match B opens the non-overlap gap by dropping bits about to change;
    // match A then loads the new pattern, so match A wins if both coincide
    if (fa) begin
      group_update = (en & nxt) | (~en & cur); // R8
    end else if (fb) begin
      group_update = cur & ~(en & (cur ^ nxt)); // R7
    end
  endfunction : group_update

  always_comb begin
    latch_next = latch_reg;
    for (int unsigned g = 0; g < tpo_pkg::TPO_GROUPS; g++) begin
      latch_next[g*4 +: 4] = group_update(latch_reg[g*4 +: 4],
        next_data_bit_reg[g*4 +: 4], enable_all[g*4 +: 4], trig.fire_a[g],
        trig.fire_b[g]);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      latch_reg <= tpo_pkg::TPO_RST_LATCH;
    end else begin
      latch_reg <= latch_next; // R8
    end
  end

  assign port_a_latch_out = latch_reg[7:0]; // R3
  assign port_b_latch_out = latch_reg[15:8]; // R2
endmodule : tpo_top

// ---- tb/tpo_sva.sv ----
// port checker for the timed pattern output block
// assumes it is bound to tpo_top and shares its clock and reset
module tpo_sva (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [17:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [3:0] cmp_match_a_in,
  input wire logic [3:0] cmp_match_b_in,
  input wire logic [7:0] port_a_latch_out,
  input wire logic [7:0] port_b_latch_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire logic take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire logic rd = take && !wb_we_in;
  property p_ack_one; take |=> wb_ack_out; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack missing");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_idle; !take |=> !wb_ack_out; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
  property p_dat_hi; wb_ack_out |-> wb_dat_out[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  // read data also reloads on a taken write, so only idle cycles hold it
  property p_dat_hold; !take |=> $stable(wb_dat_out); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_unmapped;
    rd && wb_adr_in[17:2] < 16'h00a0 |=> wb_dat_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_upper_ones;
    rd && wb_adr_in[17:3] == 15'h7fd3 |=> wb_dat_out[7:4] == 4'hf;
  endproperty
  a_upper_ones: assert property (p_upper_ones) else $error("nibble not one");
  property p_latch_hold;
    (cmp_match_a_in | cmp_match_b_in) == 4'h0 |=>
      $stable(port_a_latch_out) && $stable(port_b_latch_out);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved");
  // a match B alone may only clear port B latch bits, never set them
  property p_b_clears;
    cmp_match_a_in == 4'h0 |=> (port_b_latch_out &
      ~$past(port_b_latch_out)) == 8'h00;
  endproperty
  a_b_clears: assert property (p_b_clears) else $error("match B set bit");
endmodule : tpo_sva

// ---- tb/tpo_timer_model.sv ----
// behavioural timer unit giving compare match strobes
// assumes the bench raises each request for one cycle
module tpo_timer_model (
  input wire logic mclk_in,
  input wire logic [3:0] req_a_in,
  input wire logic [3:0] req_b_in,
  output logic [3:0] cmp_a_out,
  output logic [3:0] cmp_b_out
);
  // one register stage: a real timer flags a match on a clock edge
  always_ff @(posedge mclk_in) begin
    cmp_a_out <= req_a_in;
    cmp_b_out <= req_b_in;
  end
endmodule : tpo_timer_model

// ---- tb/test_tpo_top.sv ----
// self-checking bench for the timed pattern output block
// assumes tpo_top, the timer model and the checker are compiled first
module test_tpo_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ack;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'h1;
  logic [3:0] req_a = 4'h0;
  logic [3:0] req_b = 4'h0;
  logic [3:0] cmp_a;
  logic [3:0] cmp_b;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [7:0] pa, pb, pa_e, pb_e, q, d, e, en;
  logic [1:0] cc, oo;
  logic [15:0] ri [7] = '{16'h00a0, 16'h00a2, 16'h00a3, 16'hffa4,
                          16'hffa6, 16'hffa7, 16'h0012};
  logic [7:0] rv [7] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
  int fail_count = 0;
  int n_tests = 0;
  int seed = 70;
  int cycles = 0;
  always #4 mclk_in = ~mclk_in;
  tpo_timer_model i_tmr (.mclk_in(mclk_in), .req_a_in(req_a),
    .req_b_in(req_b), .cmp_a_out(cmp_a), .cmp_b_out(cmp_b));
  tpo_top i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .cmp_match_a_in(cmp_a), .cmp_match_b_in(cmp_b),
    .port_a_latch_out(pa), .port_b_latch_out(pb));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [7:0] s, x);
    n_tests++;
    if (s !== x) begin
      $display("ERROR %s expected %h seen %h", nm, x, s);
      fail_count++;
    end
  endtask : chk
  // request held until the edge that samples ack; read data taken there
  task automatic wb(input logic w, input logic [15:0] i, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, v};
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    if (n >= 20) fail_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic fire(input logic [3:0] a, b);
    @(posedge mclk_in);
    req_a <= a;
    req_b <= b;
    @(posedge mclk_in);
    req_a <= 4'h0;
    req_b <= 4'h0;
    @(posedge mclk_in);
    @(negedge mclk_in);
  endtask : fire
  function automatic logic [7:0] cp(input logic [7:0] o, nd, m);
    return (o & ~m) | (nd & m);
  endfunction : cp
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    pa_e = 8'h00;
    pb_e = 8'h00;
    foreach (ri[k]) begin
      wb(1'b0, ri[k], 8'h00);
      chk("reset value", q, rv[k]);
    end
    wb(1'b1, 16'hffa6, 8'h5a);
    wb(1'b0, 16'hffa6, 8'h00);
    chk("upper_b", q, 8'hff);
    wb(1'b1, 16'h00a0, 8'h00);
    for (int k = 0; k < 8; k++) begin
      en = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($random(seed));
      d = 8'($random(seed));
      e = 8'($random(seed));
      wb(1'b1, 16'h00a3, en);
      wb(1'b1, 16'h00a2, ~en);
      wb(1'b1, 16'hffa5, d);
      wb(1'b1, 16'hffa4, e);
      fire(4'h1, 4'h0);
      pa_e = cp(pa_e, d, en);
      pb_e = cp(pb_e, e, ~en);
      chk("port_a", pa, pa_e);
      chk("port_b", pb, pb_e);
    end
    // group 3 on channel c, every other group on a different channel
    wb(1'b1, 16'h00a2, 8'hff);
    for (int c = 0; c < 4; c++) begin
      cc = 2'(c);
      oo = cc ^ 2'b01;
      d = 8'($random(seed));
      e = 8'($random(seed));
      wb(1'b1, 16'h00a0, {cc, oo, oo, oo});
      wb(1'b1, 16'hffa4, d);
      wb(1'b0, 16'hffa4, 8'h00);
      chk("upper_a", q, {d[7:4], 4'hf});
      wb(1'b1, 16'hffa6, e);
      wb(1'b0, 16'hffa6, 8'h00);
      chk("upper_b", q, {4'hf, e[3:0]});
      fire(4'h1 << oo, 4'h0);
      pb_e[3:0] = e[3:0];
      chk("port_b", pb, pb_e);
      chk("port_a", pa, pa_e);
      fire(4'h1 << cc, 4'h0);
      pb_e[7:4] = d[7:4];
      chk("port_b", pb, pb_e);
    end
    // group 3 non-overlapping, group 2 stays normal and ignores match B
    wb(1'b1, 16'h00a0, 8'h00);
    wb(1'b1, 16'h00a1, 8'h08);
    sel <= 4'he;
    wb(1'b1, 16'h00a1, 8'h00);
    sel <= 4'h1;
    wb(1'b0, 16'h00a1, 8'h00);
    chk("mode", q, 8'h08);
    d = 8'($random(seed));
    wb(1'b1, 16'hffa4, d);
    fire(4'h0, 4'h1);
    pb_e = pb_e & ~(8'hf0 & (d ^ pb_e));
    chk("port_b", pb, pb_e);
    fire(4'h1, 4'h1);
    chk("port_b", pb, d);
    wrap_up();
  end
endmodule : test_tpo_top

bind tpo_top tpo_sva i_sva (.mclk_in(mclk_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .cmp_match_a_in(cmp_match_a_in), .cmp_match_b_in(cmp_match_b_in),
  .port_a_latch_out(port_a_latch_out), .port_b_latch_out(port_b_latch_out));
